/* rtl/redriver_i2c_target_access.sv */
`timescale 1ns/1ps
// How it works
// R1: the serial target port works only when the host-control strap is not low.
// R2: seven-bit target address is built from the two four-level straps.
// R3: a write address with matching target address is acknowledged.
// R4: the controller sends one register-selecting byte, MSB first.
// R5: the register-selecting byte after a write address is acknowledged.
// R6: any number of data bytes follow; each one is acknowledged.
// R7: the controller ends a write with a stop condition.
// R8: a read address with matching target address is acknowledged.
// R9: reads start at offset zero or one past the last byte read.
// R10: a register selected by an earlier write sets the read start.
// R11: after each sent byte the data line is released to sample acknowledge.
// R12: an acknowledged read byte is followed by the next register byte.
// R13: read offsets advance one byte at a time until the controller ends.
// R14: the controller ends a read with a stop condition.
// R15: an address-plus-selection write keeps the selection for the next read.
// R16: set-type fields: writing one sets, zero leaves unchanged.
// R17: clear-type fields: writing one clears, zero leaves unchanged.
// R18: update-type fields may change by device logic at any time.
// R19: the controller leaves unmapped offsets unmodified.
// R20: each further data byte of a write goes to the next offset.
module redriver_i2c_target_access #(
  parameter int DEPTH = i2c_target_pkg::REG_DEPTH,
  parameter logic [DEPTH*8-1:0] SET_MASK = '0,
  parameter logic [DEPTH*8-1:0] CLR_MASK = '0,
  parameter logic [DEPTH*8-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sclClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic [1:0] hostCtrlStrap,
  input wire logic [1:0] eqLowAddrHighStrap,
  input wire logic [1:0] addrLowStrap,
  input wire logic [DEPTH-1:0] hwWe,
  input wire logic [DEPTH*8-1:0] hwData,
  output logic [DEPTH*8-1:0] regFlat,
  output logic hostEnable,
  output logic [6:0] targetAddr
);

  // ---------------- system clock side ----------------
  logic sclSync1_q, sclSync2_q, sdaSync1_q, sdaSync2_q;
  logic sclPrev_q, sdaPrev_q, startTgl_q;
  logic wrT1_q, wrT2_q, wrT3_q, ldT1_q, ldT2_q, ldT3_q;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] rdByte;

  // ---------------- link clock side ----------------
  logic linkRst1_q, linkRst_q;
  logic st1_q, st2_q, st3_q;
  i2c_target_pkg::link_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shift_q;
  logic dirRead_q, dirRead_d, firstByte_q, firstByte_d;
  logic [7:0] wrByte_q, wrByte_d, txByte_q, txByte_d;
  logic wrFirst_q, wrFirst_d, wrTgl_q, wrTgl_d, ldTgl_q, ldTgl_d;
  logic oeN_q;

  strap_sampler uStraps (
    .sys_clk(sys_clk),
    .srst(srst),
    .hostCtrlStrap(hostCtrlStrap),
    .eqLowAddrHighStrap(eqLowAddrHighStrap),
    .addrLowStrap(addrLowStrap),
    .hostEnable(hostEnable),
    .targetAddr(targetAddr)
  );

  always_ff @(posedge sys_clk) begin
    sclSync1_q <= sclIn;
    sclSync2_q <= sclSync1_q;
    sdaSync1_q <= sdaIn;
    sdaSync2_q <= sdaSync1_q;
    sclPrev_q <= sclSync2_q;
    sdaPrev_q <= sdaSync2_q;
  end

  // start: data falls while clock stays high
  wire startSeen = sclSync2_q & sclPrev_q & sdaPrev_q & ~sdaSync2_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      startTgl_q <= 1'b0;
    end else begin
      startTgl_q <= startTgl_q ^ startSeen;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {wrT1_q, wrT2_q, wrT3_q} <= 3'h0;
      {ldT1_q, ldT2_q, ldT3_q} <= 3'h0;
    end else begin
      {wrT1_q, wrT2_q, wrT3_q} <= {wrTgl_q, wrT1_q, wrT2_q};
      {ldT1_q, ldT2_q, ldT3_q} <= {ldTgl_q, ldT1_q, ldT2_q};
    end
  end

  wire wrEvent = wrT2_q ^ wrT3_q;
  wire loadEvent = ldT2_q ^ ldT3_q;
  // byte and its kind are held by the link until its next toggle
  wire busWe = wrEvent & ~wrFirst_q;
  wire [7:0] ptrNext = ptr_q + i2c_target_pkg::PTR_STEP;

  always_comb begin
    ptr_d = ptr_q;
    if (wrEvent && wrFirst_q) begin
      // R10: selection byte becomes the pointer
      ptr_d = wrByte_q;
    end else if (wrEvent) begin
      // R20: next data byte, next offset
      ptr_d = ptrNext;
    end else if (loadEvent) begin
      // R13: pointer runs one ahead of the byte in flight
      ptr_d = ptrNext;
    end
  end

  // R9 R15: pointer starts at zero, holds between bytes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_q <= i2c_target_pkg::PTR_RESET;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  reg_bank #(
    .DEPTH(DEPTH),
    .AW(i2c_target_pkg::REG_AW),
    .SET_MASK(SET_MASK),
    .CLR_MASK(CLR_MASK),
    .RESET_VAL(RESET_VAL)
  ) uRegs (
    .sys_clk(sys_clk),
    .srst(srst),
    .busWe(busWe),
    .busAddr(ptr_q),
    .busData(wrByte_q),
    .rdAddr(ptr_q),
    .rdData(rdByte),
    .hwWe(hwWe),
    .hwData(hwData),
    .regFlat(regFlat)
  );

  // ---------------- link logic on the serial clock ----------------
  always_ff @(posedge sclClk) begin
    linkRst1_q <= srst;
    linkRst_q <= linkRst1_q;
  end

  // frame bits keep shifting while the link leaves reset
  always_ff @(posedge sclClk) begin
    st1_q <= startTgl_q;
    st2_q <= st1_q;
    st3_q <= st2_q;
    shift_q <= {shift_q[6:0], sdaIn};
  end

  wire startEdge = st2_q ^ st3_q;
  wire [7:0] nextByte = {shift_q[6:0], sdaIn};
  wire lastBit = cnt_q == i2c_target_pkg::LAST_BIT;
  wire [2:0] cntInc = cnt_q + 3'h1;
  wire addrMatch = hostEnable && nextByte[7:1] == targetAddr;
  wire [2:0] bitSel = i2c_target_pkg::LAST_BIT - cnt_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    dirRead_d = dirRead_q;
    firstByte_d = firstByte_q;
    wrByte_d = wrByte_q;
    wrFirst_d = wrFirst_q;
    wrTgl_d = wrTgl_q;
    txByte_d = txByte_q;
    ldTgl_d = ldTgl_q;
    if (startEdge) begin
      state_d = i2c_target_pkg::LINK_ADDR;
      cnt_d = i2c_target_pkg::START_BITS;
    end else begin
      case (state_q)
        i2c_target_pkg::LINK_ADDR: begin
          cnt_d = cntInc;
          if (lastBit) begin
            // R3: match gives an acknowledge
            state_d = addrMatch ? i2c_target_pkg::LINK_ACK_ADDR
                                : i2c_target_pkg::LINK_IDLE;
            dirRead_d = nextByte[0];
          end
        end
        i2c_target_pkg::LINK_ACK_ADDR: begin
          cnt_d = 3'h0;
          if (dirRead_q == i2c_target_pkg::DIR_READ) begin
            // R8: read begins at the pointer byte
            txByte_d = rdByte;
            ldTgl_d = ~ldTgl_q;
            state_d = i2c_target_pkg::LINK_TX;
          end else begin
            firstByte_d = 1'b1;
            state_d = i2c_target_pkg::LINK_RX;
          end
        end
        i2c_target_pkg::LINK_RX: begin
          cnt_d = cntInc;
          if (lastBit) begin
            // R4: first byte after the address selects
            wrByte_d = nextByte;
            wrFirst_d = firstByte_q;
            wrTgl_d = ~wrTgl_q;
            state_d = i2c_target_pkg::LINK_ACK_RX;
          end
        end
        i2c_target_pkg::LINK_ACK_RX: begin
          firstByte_d = 1'b0;
          state_d = i2c_target_pkg::LINK_RX;
        end
        i2c_target_pkg::LINK_TX: begin
          cnt_d = cntInc;
          if (lastBit) begin
            state_d = i2c_target_pkg::LINK_ACK_TX;
          end
        end
        i2c_target_pkg::LINK_ACK_TX: begin
          cnt_d = 3'h0;
          // R12: acknowledge fetches the next byte
          if (!sdaIn) begin
            txByte_d = rdByte;
            ldTgl_d = ~ldTgl_q;
            state_d = i2c_target_pkg::LINK_TX;
          end else begin
            state_d = i2c_target_pkg::LINK_IDLE;
          end
        end
        i2c_target_pkg::LINK_IDLE: state_d = i2c_target_pkg::LINK_IDLE;
        default: state_d = i2c_target_pkg::LINK_IDLE;
      endcase
    end
  end

  always_ff @(posedge sclClk) begin
    if (linkRst_q) begin
      state_q <= i2c_target_pkg::LINK_IDLE;
      cnt_q <= 3'h0;
      {dirRead_q, firstByte_q, wrFirst_q, wrTgl_q, ldTgl_q} <= 5'h00;
      wrByte_q <= 8'h00;
      txByte_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      {dirRead_q, firstByte_q, wrFirst_q} <=
        {dirRead_d, firstByte_d, wrFirst_d};
      {wrTgl_q, ldTgl_q} <= {wrTgl_d, ldTgl_d};
      wrByte_q <= wrByte_d;
      txByte_q <= txByte_d;
    end
  end

  // R5 R6: acknowledge slots pull low; sent bits pull low for zeros
  wire ackSlot = state_q == i2c_target_pkg::LINK_ACK_ADDR ||
                 state_q == i2c_target_pkg::LINK_ACK_RX;
  wire sendZero = state_q == i2c_target_pkg::LINK_TX && !txByte_q[bitSel];

  // R11: outside these slots the line is released
  always_ff @(negedge sclClk) begin
    if (linkRst_q) begin
      oeN_q <= 1'b1;
    end else begin
      oeN_q <= ~(ackSlot | sendZero);
    end
  end

  assign sdaOut = 1'b0;
  // R1: port silent unless the strap enabled it
  assign sdaOeN = oeN_q | ~hostEnable;

  chk_ptr_reset: assert property ( // R9
    @(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> ptr_q == i2c_target_pkg::PTR_RESET)
    else $error("pointer not zero after reset");

  chk_ptr_select: assert property ( // R10
    @(posedge sys_clk) disable iff (srst)
    (wrEvent && wrFirst_q) |=> ptr_q == $past(wrByte_q))
    else $error("selection byte not taken as pointer");

  chk_write_advance: assert property ( // R20
    @(posedge sys_clk) disable iff (srst)
    busWe |=> ptr_q == $past(ptrNext))
    else $error("pointer did not step after data byte");

  chk_read_advance: assert property ( // R13
    @(posedge sys_clk) disable iff (srst)
    (loadEvent && !wrEvent) |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not step after read byte");

  chk_ptr_keep: assert property ( // R15
    @(posedge sys_clk) disable iff (srst)
    (!wrEvent && !loadEvent) |=> $stable(ptr_q))
    else $error("pointer moved without a byte");

  chk_port_off: assert property ( // R1
    @(posedge sys_clk) disable iff (srst)
    !hostEnable |-> sdaOeN)
    else $error("data line driven while port disabled");

  chk_ack_drive: assert property ( // R3
    @(posedge sclClk) disable iff (linkRst_q)
    (state_q == i2c_target_pkg::LINK_ACK_ADDR ||
     state_q == i2c_target_pkg::LINK_ACK_RX) |-> !oeN_q)
    else $error("acknowledge slot not driven low");

  chk_ack_release: assert property ( // R11
    @(posedge sclClk) disable iff (linkRst_q)
    state_q == i2c_target_pkg::LINK_ACK_TX |-> oeN_q)
    else $error("data line held during controller acknowledge");

  chk_msb_first: assert property ( // R4
    @(posedge sclClk) disable iff (linkRst_q)
    state_q == i2c_target_pkg::LINK_TX |-> oeN_q == txByte_q[bitSel])
    else $error("sent bit does not match byte order");

  chk_next_byte: assert property ( // R12
    @(posedge sclClk) disable iff (linkRst_q)
    (state_q == i2c_target_pkg::LINK_ACK_TX && !sdaIn && !startEdge) |=>
    (state_q == i2c_target_pkg::LINK_TX && txByte_q == $past(rdByte)))
    else $error("next byte not loaded after acknowledge");

  chk_rx_capture: assert property ( // R6
    @(posedge sclClk) disable iff (linkRst_q)
    (state_q == i2c_target_pkg::LINK_RX && lastBit && !startEdge) |=>
    (state_q == i2c_target_pkg::LINK_ACK_RX && wrByte_q == $past(nextByte)))
    else $error("received byte not captured and acknowledged");

endmodule

/* rtl/i2c_target_pkg.sv */
package i2c_target_pkg;

  // register window reached through the sub-address byte
  localparam int REG_DEPTH = 64;
  localparam int REG_AW = 6;

  // four-level strap codes as presented on the strap inputs
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_R = 2'h1;
  localparam logic [1:0] LVL_F = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  // upper five target address bits per high-address strap level
  localparam logic [4:0] UPPER_AT_LOW = 5'h11;
  localparam logic [4:0] UPPER_AT_R = 5'h08;
  localparam logic [4:0] UPPER_AT_F = 5'h04;
  localparam logic [4:0] UPPER_AT_HIGH = 5'h03;

  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // bits already shifted when the start event reaches the link side
  localparam logic [2:0] START_BITS = 3'h3;
  localparam logic DIR_READ = 1'b1;

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ACK_ADDR,
    LINK_RX,
    LINK_ACK_RX,
    LINK_TX,
    LINK_ACK_TX
  } link_state_t;

endpackage

/* rtl/strap_sampler.sv */
`timescale 1ns/1ps
module strap_sampler (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] hostCtrlStrap,
  input wire logic [1:0] eqLowAddrHighStrap,
  input wire logic [1:0] addrLowStrap,
  output logic hostEnable,
  output logic [6:0] targetAddr
);

  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic armed_q;

  function automatic logic [4:0] upperBits(input logic [1:0] lvl);
    case (lvl)
      i2c_target_pkg::LVL_LOW: upperBits = i2c_target_pkg::UPPER_AT_LOW;
      i2c_target_pkg::LVL_R: upperBits = i2c_target_pkg::UPPER_AT_R;
      i2c_target_pkg::LVL_F: upperBits = i2c_target_pkg::UPPER_AT_F;
      default: upperBits = i2c_target_pkg::UPPER_AT_HIGH;
    endcase
  endfunction

  wire [1:0] ctlLvl = sync2_q[5:4];
  wire [1:0] highLvl = sync2_q[3:2];
  wire [1:0] lowLvl = sync2_q[1:0];

  always_ff @(posedge sys_clk) begin
    sync1_q <= {hostCtrlStrap, eqLowAddrHighStrap, addrLowStrap};
    sync2_q <= sync1_q;
  end

  // straps are caught once, on the first edge after reset release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      armed_q <= 1'b1;
      hostEnable <= 1'b0;
      targetAddr <= 7'h00;
    end else if (armed_q) begin
      armed_q <= 1'b0;
      // R1: serial port on
      hostEnable <= (ctlLvl != i2c_target_pkg::LVL_LOW);
      // R2: address from straps
      targetAddr <= {upperBits(highLvl), lowLvl};
    end
  end

endmodule

/* rtl/reg_bank.sv */
`timescale 1ns/1ps
module reg_bank #(
  parameter int DEPTH = i2c_target_pkg::REG_DEPTH,
  parameter int AW = i2c_target_pkg::REG_AW,
  parameter logic [DEPTH*8-1:0] SET_MASK = '0,
  parameter logic [DEPTH*8-1:0] CLR_MASK = '0,
  parameter logic [DEPTH*8-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic busWe,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busData,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData,
  input wire logic [DEPTH-1:0] hwWe,
  input wire logic [DEPTH*8-1:0] hwData,
  output logic [DEPTH*8-1:0] regFlat
);

  logic [7:0] mem_q [DEPTH];

  function automatic logic [7:0] merge(input logic [7:0] old,
      input logic [7:0] d, input logic [7:0] sm, input logic [7:0] cm);
    merge = (d & ~sm & ~cm) | ((old | d) & sm) | (old & ~d & cm);
  endfunction

  wire wrInRange = int'(busAddr) < DEPTH;
  wire rdInRange = int'(rdAddr) < DEPTH;
  wire [AW-1:0] wIdx = busAddr[AW-1:0];
  wire [7:0] setAt = SET_MASK[int'(wIdx)*8 +: 8];
  wire [7:0] clrAt = CLR_MASK[int'(wIdx)*8 +: 8];
  wire [7:0] oldAt = mem_q[wIdx];

  // R18: hardware update wins over a bus write
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (srst) begin
        mem_q[i] <= RESET_VAL[i*8 +: 8];
      end else if (hwWe[i]) begin
        mem_q[i] <= hwData[i*8 +: 8];
      end else if (busWe && wrInRange && int'(wIdx) == i) begin
        mem_q[i] <= merge(mem_q[i], busData, SET_MASK[i*8 +: 8],
                          CLR_MASK[i*8 +: 8]);
      end
    end
  end

  // unmapped offsets read as zero
  always_ff @(posedge sys_clk) begin
    rdData <= rdInRange ? mem_q[rdAddr[AW-1:0]] : 8'h00;
  end

  for (genvar g = 0; g < DEPTH; g++) begin : gFlat
    assign regFlat[g*8 +: 8] = mem_q[g];
  end

  chk_set_field: assert property ( // R16
    @(posedge sys_clk) disable iff (srst)
    (busWe && wrInRange && !hwWe[wIdx]) |=>
    ((mem_q[$past(wIdx)] & $past(setAt)) ==
     (($past(oldAt) | $past(busData)) & $past(setAt))))
    else $error("set-type field did not follow write of ones");

  chk_clear_field: assert property ( // R17
    @(posedge sys_clk) disable iff (srst)
    (busWe && wrInRange && !hwWe[wIdx]) |=>
    ((mem_q[$past(wIdx)] & $past(clrAt)) ==
     ($past(oldAt) & ~$past(busData) & $past(clrAt))))
    else $error("clear-type field did not follow write of ones");

endmodule

/* test/i2c_ctrl_model.sv */
`timescale 1ns/1ps
module i2c_ctrl_model (
  output logic scl,
  output logic sdaPull,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // clocks with data released, used while the target sits in reset
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #15 scl = 1'b0;
      #15 scl = 1'b1;
    end
  endtask
  task automatic start_cond();
    sdaPull = 1'b0;
    #7.5 scl = 1'b1;
    #30 sdaPull = 1'b1;
    #30 scl = 1'b0;
    #60;
  endtask
  // data changes in the low phase, sampled at the rising edge
  task automatic clk_bit(input logic b, output logic r);
    sdaPull = ~b;
    #7.5 scl = 1'b1;
    r = sda;
    #15 scl = 1'b0;
    #7.5;
  endtask
  // byte sent MSB first, then the slot is released
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, ack);
  endtask
  // ack every byte that should be followed by another
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~more, r);
  endtask
  // stop ends each transaction, clock then stands high
  task automatic stop_cond();
    sdaPull = 1'b1;
    #7.5 scl = 1'b1;
    #15 sdaPull = 1'b0;
    #15;
  endtask
endmodule

/* test/redriver_i2c_target_access_tb.sv */
`timescale 1ns/1ps
module redriver_i2c_target_access_tb;
  localparam logic [511:0] RST_V = 512'h0F00_1277;
  localparam logic [511:0] SET_V = 512'hF0_0000;
  localparam logic [511:0] CLR_V = 512'h0F00_0000;
  logic sys_clk;
  logic srst;
  logic scl;
  logic sdaPull;
  logic sda;
  logic sdaOut;
  logic sdaOeN;
  logic [1:0] hostCtrlStrap;
  logic [1:0] eqLowAddrHighStrap;
  logic [1:0] addrLowStrap;
  logic [63:0] hwWe;
  logic [511:0] hwData;
  logic [511:0] regFlat;
  logic hostEnable;
  logic [6:0] targetAddr;
  logic [6:0] devAddr;
  int num_errors;
  int checks;

  // open-drain wire with pull-up
  assign sda = ~sdaPull & (sdaOeN | sdaOut);

  redriver_i2c_target_access #(
    .SET_MASK(SET_V),
    .CLR_MASK(CLR_V),
    .RESET_VAL(RST_V)
  ) i_dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .sclClk(scl),
    .sclIn(scl),
    .sdaIn(sda),
    .sdaOut(sdaOut),
    .sdaOeN(sdaOeN),
    .hostCtrlStrap(hostCtrlStrap),
    .eqLowAddrHighStrap(eqLowAddrHighStrap),
    .addrLowStrap(addrLowStrap),
    .hwWe(hwWe),
    .hwData(hwData),
    .regFlat(regFlat),
    .hostEnable(hostEnable),
    .targetAddr(targetAddr)
  );

  i2c_ctrl_model i_ctrl (
    .scl(scl),
    .sdaPull(sdaPull),
    .sda(sda)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic wrap_up();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      num_errors++;
    end
  endtask

  task automatic do_reset(input logic [1:0] hc, input logic [1:0] hi,
                          input logic [1:0] lo);
    @(posedge sys_clk);
    srst <= 1'b1;
    hostCtrlStrap <= hc;
    eqLowAddrHighStrap <= hi;
    addrLowStrap <= lo;
    fork
      repeat (16) @(posedge sys_clk);
      i_ctrl.idle_clocks(4);
    join
    srst <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic wait_reg(input int idx, input logic [7:0] exp);
    int k;
    k = 0;
    while (regFlat[8*idx +: 8] !== exp && k < 40) begin
      @(posedge sys_clk);
      k++;
    end
    chk(regFlat[8*idx +: 8], exp, "register value");
  endtask

  task automatic wr_seq(input logic [7:0] sub, input int n,
                        input logic [31:0] d);
    logic a;
    i_ctrl.start_cond();
    i_ctrl.send_byte({devAddr, 1'b0}, a);
    chk({7'h00, a}, 8'h00, "write address ack");
    i_ctrl.send_byte(sub, a);
    chk({7'h00, a}, 8'h00, "selection ack");
    for (int i = 0; i < n; i++) begin
      i_ctrl.send_byte(d[31-8*i -: 8], a);
      chk({7'h00, a}, 8'h00, "data ack");
    end
    i_ctrl.stop_cond();
  endtask

  task automatic rd_seq(input int n, input logic [31:0] exp);
    logic a;
    logic [7:0] d;
    i_ctrl.start_cond();
    i_ctrl.send_byte({devAddr, 1'b1}, a);
    chk({7'h00, a}, 8'h00, "read address ack");
    for (int i = 0; i < n; i++) begin
      i_ctrl.get_byte(i < n - 1, d);
      chk(d, exp[31-8*i -: 8], "read byte");
    end
    i_ctrl.stop_cond();
  endtask

  task automatic t_read_from_zero();
    rd_seq(2, 32'h7712_0000);
  endtask

  task automatic t_write_burst();
    logic a;
    wr_seq(8'h05, 4, 32'hA53C_815A);
    wait_reg(5, 8'hA5);
    wait_reg(6, 8'h3C);
    wait_reg(7, 8'h81);
    wait_reg(8, 8'h5A);
    i_ctrl.start_cond();
    i_ctrl.send_byte({devAddr ^ 7'h01, 1'b0}, a);
    chk({7'h00, a}, 8'h01, "foreign address ack");
    i_ctrl.stop_cond();
  endtask

  task automatic t_select_read();
    wr_seq(8'h05, 0, 32'h0);
    rd_seq(3, 32'hA53C_8100);
    rd_seq(1, 32'h5A00_0000);
  endtask

  task automatic t_set_clear();
    wr_seq(8'h02, 2, 32'h3C05_0000);
    wait_reg(2, 8'h3C);
    wait_reg(3, 8'h0A);
    wr_seq(8'h02, 2, 32'h0);
    wait_reg(2, 8'h30);
    wait_reg(3, 8'h0A);
  endtask

  task automatic t_hw_update();
    @(posedge sys_clk);
    hwData[8*9 +: 8] <= 8'hC3;
    hwWe[9] <= 1'b1;
    @(posedge sys_clk);
    hwWe[9] <= 1'b0;
    wait_reg(9, 8'hC3);
    wr_seq(8'h09, 0, 32'h0);
    rd_seq(1, 32'hC300_0000);
  endtask

  task automatic t_straps();
    logic [4:0] up [4];
    logic a;
    up = '{5'h11, 5'h08, 5'h04, 5'h03};
    for (int h = 0; h < 4; h++) begin
      for (int l = 0; l < 4; l++) begin
        do_reset(2'(h % 3 + 1), 2'(h), 2'(l));
        chk({7'h00, hostEnable}, 8'h01, "port enable");
        chk({1'b0, targetAddr}, {1'b0, up[h], 2'(l)}, "address");
      end
    end
    do_reset(2'h0, 2'h1, 2'h2);
    chk({7'h00, hostEnable}, 8'h00, "port disabled");
    i_ctrl.start_cond();
    i_ctrl.send_byte({7'h22, 1'b0}, a);
    chk({7'h00, a}, 8'h01, "ack while disabled");
    i_ctrl.stop_cond();
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    $display("BAD %0t run did not finish", $time);
    num_errors++;
    wrap_up();
  end

  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    hostCtrlStrap = 2'h3;
    eqLowAddrHighStrap = 2'h1;
    addrLowStrap = 2'h2;
    hwWe = '0;
    hwData = '0;
    num_errors = 0;
    checks = 0;
    // straps R and F give target address 0100010
    devAddr = 7'h22;
    do_reset(2'h3, 2'h1, 2'h2);
    t_read_from_zero();
    t_write_burst();
    t_select_read();
    t_set_clear();
    t_hw_update();
    t_straps();
    wrap_up();
  end
endmodule
